// >>> pkg/cet_pkg.sv
// Shared constants for the event matching system
`default_nettype none
package cet_pkg;
  localparam int ADDR_W    = 24;         // Emulated bus address width
  localparam int DATA_W    = 16;         // Emulated bus data width
  localparam int TYPE_W    = 3;          // Access type code width
  localparam int AREA_W    = 2;          // Access area code width
  localparam int NUM_PROBE = 4;          // External probes
  localparam int NUM_EVT   = 8;          // Event channels, also chain length
  localparam int NUM_RNG   = 4;          // Range channels
  localparam int NUM_CH    = NUM_EVT + NUM_RNG;  // At most twelve
  localparam int NUM_MON   = 4;          // Trigger monitor addresses
  localparam int CNT_W     = 16;         // Occurrence and delay counters
  localparam int TMR_W     = 32;         // Elapsed time counter
  localparam int SEL_W     = 4;          // Channel index width
  localparam logic [CNT_W-1:0] BRK_DLY_MAX = 16'hFFFF;  // Longest break delay
  localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
  localparam logic [TMR_W-1:0] TMR_ZERO    = 32'h0000_0000;
  localparam logic [TMR_W-1:0] TMR_ONE     = 32'h0000_0001;
  localparam logic [NUM_EVT-1:0] ARM_RESET = 8'hFF;  // Armed after reset
  localparam logic [1:0] DIR_READ  = 2'h1;   // Direction select codes
  localparam logic [1:0] DIR_WRITE = 2'h2;
  localparam logic [1:0] DIR_EITHER = 2'h3;
endpackage
`default_nettype wire

// >>> design/cet_channel.sv
// One event or range channel: match, occurrence count and delay
`default_nettype none
module cet_channel #(
  parameter bit EVENT_CH = 1'b1
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          clear,
  input  wire logic                          bus_cycle,
  input  wire logic [cet_pkg::ADDR_W-1:0]    bus_addr,
  input  wire logic [cet_pkg::DATA_W-1:0]    bus_data,
  input  wire logic                          bus_write,
  input  wire logic [cet_pkg::TYPE_W-1:0]    bus_type,
  input  wire logic [cet_pkg::AREA_W-1:0]    bus_area,
  input  wire logic [cet_pkg::NUM_PROBE-1:0] probes,
  input  wire logic                          cfg_enable,
  input  wire logic [cet_pkg::ADDR_W-1:0]    cfg_addr_lo,
  input  wire logic [cet_pkg::ADDR_W-1:0]    cfg_addr_hi,
  input  wire logic                          cfg_outside,
  input  wire logic [cet_pkg::DATA_W-1:0]    cfg_data,
  input  wire logic [cet_pkg::DATA_W-1:0]    cfg_mask,
  input  wire logic [1:0]                    cfg_dir,
  input  wire logic [(1<<cet_pkg::TYPE_W)-1:0] cfg_type,
  input  wire logic [(1<<cet_pkg::AREA_W)-1:0] cfg_area,
  input  wire logic [cet_pkg::NUM_PROBE-1:0] cfg_probe_care,
  input  wire logic [cet_pkg::NUM_PROBE-1:0] cfg_probe_val,
  input  wire logic [cet_pkg::CNT_W-1:0]     cfg_count,
  input  wire logic [cet_pkg::CNT_W-1:0]     cfg_delay,
  input  wire logic                          armed,
  output logic                               hit
);
  logic                      in_range;
  logic                      match;
  logic                      qualify;
  logic [cet_pkg::CNT_W-1:0] target;
  logic [cet_pkg::CNT_W-1:0] occ_reg, occ_next;
  logic [cet_pkg::CNT_W-1:0] dly_reg, dly_next;
  logic                      pend_reg, pend_next;
  logic                      hit_reg, hit_next;

  // Qualify one bus cycle against every enabled condition
  always_comb begin
    in_range = (bus_addr >= cfg_addr_lo) && (bus_addr <= cfg_addr_hi);
    match = cfg_enable && armed && bus_cycle
      && ((EVENT_CH && cfg_outside) ? !in_range : in_range)
      && (((bus_data ^ cfg_data) & cfg_mask) == '0)
      && (bus_write ? cfg_dir[1] : cfg_dir[0])
      && cfg_type[bus_type] && cfg_area[bus_area]
      && (((probes ^ cfg_probe_val) & cfg_probe_care) == '0);
  end

  // Occurrence count, then delay in bus cycles before the output
  always_comb begin
    target = (EVENT_CH && cfg_count != cet_pkg::CNT_ZERO) ?
             cfg_count : cet_pkg::CNT_ONE;
    occ_next  = occ_reg;
    dly_next  = dly_reg;
    pend_next = pend_reg;
    hit_next  = 1'b0;
    qualify   = 1'b0;
    if (match) begin
      if (occ_reg + cet_pkg::CNT_ONE >= target) begin
        qualify  = 1'b1;
        occ_next = cet_pkg::CNT_ZERO;
      end else begin
        occ_next = occ_reg + cet_pkg::CNT_ONE;
      end
    end
    if (pend_reg && bus_cycle) begin
      dly_next = dly_reg - cet_pkg::CNT_ONE;
      if (dly_reg == cet_pkg::CNT_ONE) begin
        pend_next = 1'b0;
        hit_next  = 1'b1;
      end
    end else if (qualify && !pend_reg) begin
      if (cfg_delay == cet_pkg::CNT_ZERO) begin
        hit_next = 1'b1;
      end else begin
        pend_next = 1'b1;
        dly_next  = cfg_delay;
      end
    end
    if (clear) begin
      occ_next  = cet_pkg::CNT_ZERO;
      dly_next  = cet_pkg::CNT_ZERO;
      pend_next = 1'b0;
      hit_next  = 1'b0;
    end
  end

  // Channel state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      occ_reg  <= cet_pkg::CNT_ZERO;
      dly_reg  <= cet_pkg::CNT_ZERO;
      pend_reg <= 1'b0;
      hit_reg  <= 1'b0;
    end else begin
      occ_reg  <= occ_next;
      dly_reg  <= dly_next;
      pend_reg <= pend_next;
      hit_reg  <= hit_next;
    end
  end

  assign hit = hit_reg;

  // Checks on the channel output
  hit_pulse_a: assert property (@(posedge clock) disable iff (rst)
    hit && !match |=> !hit)
    else $error("channel hit longer than one cycle");
  no_delay_hit_a: assert property (@(posedge clock) disable iff (rst)
    match && !pend_reg && !clear && target == cet_pkg::CNT_ONE
    && cfg_delay == cet_pkg::CNT_ZERO |=> hit)
    else $error("undelayed match gave no hit");
endmodule
`default_nettype wire

// >>> design/cet_top.sv
// Event matching system: channels, sequencing, break, trace, timer
// Functional notes
// - Event channel matches address, outside range, data, direction, type, area, probes.
// - Event channel reports only after the programmed number of matches.
// - Event and range channels delay their output by programmed cycles.
// - Up to eight events chain; each occurrence arms or disarms the next.
// - Range channels match like events but no outside range or counting.
// - A channel selected in break_sel halts the emulated program; a final sequence event only if selected.
// - Break may be postponed up to 65535 bus cycles after activation.
// - Timer measures time from a first to a second selected event.
// - Channel matches drive trace, break and timing together.
// - Level of the first probe input is a selectable match condition.
// - Second probe goes high while a monitor condition one to four holds.
// - Event and range channels total at most twelve break conditions.
// - Trigger output follows accesses to up to four monitor addresses.
`default_nettype none
module cet_top (
  input  wire logic                            clock,
  input  wire logic                            rst,
  input  wire logic                            emu_start,
  input  wire logic                            bus_cycle,
  input  wire logic [cet_pkg::ADDR_W-1:0]      bus_addr,
  input  wire logic [cet_pkg::DATA_W-1:0]      bus_data,
  input  wire logic                            bus_write,
  input  wire logic [cet_pkg::TYPE_W-1:0]      bus_type,
  input  wire logic [cet_pkg::AREA_W-1:0]      bus_area,
  input  wire logic                            level_probe_input,
  input  wire logic [cet_pkg::NUM_PROBE-1:1]   probe_in,
  input  wire logic [cet_pkg::NUM_CH-1:0]      ch_enable,
  input  wire logic [cet_pkg::NUM_CH-1:0][cet_pkg::ADDR_W-1:0] ch_addr_lo,
  input  wire logic [cet_pkg::NUM_CH-1:0][cet_pkg::ADDR_W-1:0] ch_addr_hi,
  input  wire logic [cet_pkg::NUM_EVT-1:0]     ev_outside,
  input  wire logic [cet_pkg::NUM_CH-1:0][cet_pkg::DATA_W-1:0] ch_data,
  input  wire logic [cet_pkg::NUM_CH-1:0][cet_pkg::DATA_W-1:0] ch_mask,
  input  wire logic [cet_pkg::NUM_CH-1:0][1:0] ch_dir,
  input  wire logic [cet_pkg::NUM_CH-1:0][(1<<cet_pkg::TYPE_W)-1:0] ch_type,
  input  wire logic [cet_pkg::NUM_CH-1:0][(1<<cet_pkg::AREA_W)-1:0] ch_area,
  input  wire logic [cet_pkg::NUM_CH-1:0][cet_pkg::NUM_PROBE-1:0] ch_pcare,
  input  wire logic [cet_pkg::NUM_CH-1:0][cet_pkg::NUM_PROBE-1:0] ch_pval,
  input  wire logic [cet_pkg::NUM_EVT-1:0][cet_pkg::CNT_W-1:0] ev_count,
  input  wire logic [cet_pkg::NUM_CH-1:0][cet_pkg::CNT_W-1:0] ch_delay,
  input  wire logic [cet_pkg::NUM_EVT-1:1]     chain_en,
  input  wire logic [cet_pkg::NUM_EVT-1:1]     chain_disarm,
  input  wire logic [cet_pkg::NUM_CH-1:0]      break_sel,
  input  wire logic                            break_delay_en,
  input  wire logic [cet_pkg::CNT_W-1:0]       break_delay,
  input  wire logic [cet_pkg::NUM_CH-1:0]      trace_sel,
  input  wire logic [cet_pkg::SEL_W-1:0]       timer_start_sel,
  input  wire logic [cet_pkg::SEL_W-1:0]       timer_stop_sel,
  input  wire logic [cet_pkg::NUM_MON-1:0]     mon_enable,
  input  wire logic [cet_pkg::NUM_MON-1:0][cet_pkg::ADDR_W-1:0] mon_addr,
  output logic [cet_pkg::NUM_CH-1:0]           ch_hit,
  output logic                                 break_out,
  output logic                                 trace_acquire,
  output logic                                 timer_running,
  output logic [cet_pkg::TMR_W-1:0]            timer_count,
  output logic                                 trigger_probe_output
);
  logic [cet_pkg::NUM_PROBE-1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [cet_pkg::NUM_PROBE-1:0] probe_reg, probe_next;
  logic [cet_pkg::NUM_EVT-1:0]   armed_reg, armed_next;
  logic [cet_pkg::NUM_EVT-1:0]   arm_init;
  logic [cet_pkg::NUM_CH-1:0]    hits;
  logic                          brk_trig;
  logic                          brk_pend_reg, brk_pend_next;
  logic [cet_pkg::CNT_W-1:0]     brk_cnt_reg, brk_cnt_next;
  logic                          break_reg, break_next;
  logic                          trace_reg, trace_next;
  logic                          trig_reg, trig_next;
  logic                          run_reg, run_next;
  logic [cet_pkg::TMR_W-1:0]     tmr_reg, tmr_next;
  logic                          t_start, t_stop;

  // Probe pins pass three flip-flops; a change counts once stages 2 and 3 agree
  always_comb begin
    for (int p = 0; p < cet_pkg::NUM_PROBE; p++) begin
      probe_next[p] = (sync2_reg[p] == sync3_reg[p]) ? sync3_reg[p]
                                                     : probe_reg[p];
    end
  end

  // Probe synchroniser registers
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      probe_reg <= '0;
    end else begin
      sync1_reg <= {probe_in, level_probe_input};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      probe_reg <= probe_next;
    end
  end

  // Twelve channels: the first eight count and may match outside a range
  generate
    for (genvar k = 0; k < cet_pkg::NUM_CH; k++) begin : g_ch
      localparam bit IS_EV = (k < cet_pkg::NUM_EVT);
      logic                      k_outside;
      logic [cet_pkg::CNT_W-1:0] k_count;
      logic                      k_armed;
      if (IS_EV) begin : g_ev
        assign k_outside = ev_outside[k];
        assign k_count   = ev_count[k];
        assign k_armed   = armed_reg[k];
      end else begin : g_rng
        assign k_outside = 1'b0;
        assign k_count   = cet_pkg::CNT_ZERO;
        assign k_armed   = 1'b1;
      end
      cet_channel #(.EVENT_CH(IS_EV)) u_ch (
        .clock          (clock),
        .rst            (rst),
        .clear          (emu_start),
        .bus_cycle      (bus_cycle),
        .bus_addr       (bus_addr),
        .bus_data       (bus_data),
        .bus_write      (bus_write),
        .bus_type       (bus_type),
        .bus_area       (bus_area),
        .probes         (probe_reg),
        .cfg_enable     (ch_enable[k]),
        .cfg_addr_lo    (ch_addr_lo[k]),
        .cfg_addr_hi    (ch_addr_hi[k]),
        .cfg_outside    (k_outside),
        .cfg_data       (ch_data[k]),
        .cfg_mask       (ch_mask[k]),
        .cfg_dir        (ch_dir[k]),
        .cfg_type       (ch_type[k]),
        .cfg_area       (ch_area[k]),
        .cfg_probe_care (ch_pcare[k]),
        .cfg_probe_val  (ch_pval[k]),
        .cfg_count      (k_count),
        .cfg_delay      (ch_delay[k]),
        .armed          (k_armed),
        .hit            (hits[k])
      );
    end
  endgenerate

  // Sequence arming: a chained event waits to be armed, or runs until disarmed
  always_comb begin
    arm_init    = cet_pkg::ARM_RESET;
    armed_next  = armed_reg;
    for (int i = 1; i < cet_pkg::NUM_EVT; i++) begin
      arm_init[i] = chain_en[i] ? chain_disarm[i] : 1'b1;
      if (chain_en[i] && hits[i-1]) begin
        armed_next[i] = !chain_disarm[i];
      end else if (!chain_en[i]) begin
        armed_next[i] = 1'b1;
      end
    end
    armed_next[0] = 1'b1;
    if (emu_start) begin
      armed_next = arm_init;
    end
  end

  // Break with optional postponement in bus cycles
  always_comb begin
    brk_trig      = |(hits & break_sel);
    brk_pend_next = brk_pend_reg;
    brk_cnt_next  = brk_cnt_reg;
    break_next    = 1'b0;
    if (brk_pend_reg && bus_cycle) begin
      brk_cnt_next = brk_cnt_reg - cet_pkg::CNT_ONE;
      if (brk_cnt_reg == cet_pkg::CNT_ONE) begin
        brk_pend_next = 1'b0;
        break_next    = 1'b1;
      end
    end else if (brk_trig && !brk_pend_reg) begin
      if (!break_delay_en || break_delay == cet_pkg::CNT_ZERO) begin
        break_next = 1'b1;
      end else begin
        brk_pend_next = 1'b1;
        brk_cnt_next  = break_delay;
      end
    end
    if (emu_start) begin
      brk_pend_next = 1'b0;
      brk_cnt_next  = cet_pkg::CNT_ZERO;
      break_next    = 1'b0;
    end
  end

  // Trace and timer fed by the same channel hits; trigger probe fed by monitor addresses
  always_comb begin
    trace_next = |(hits & trace_sel);
    // Indexes past the last channel never hit
    t_start    = (int'(timer_start_sel) < cet_pkg::NUM_CH)
                 && hits[timer_start_sel];
    t_stop     = (int'(timer_stop_sel) < cet_pkg::NUM_CH)
                 && hits[timer_stop_sel];
    run_next   = run_reg;
    tmr_next   = run_reg ? tmr_reg + cet_pkg::TMR_ONE : tmr_reg;
    if (t_start && !run_reg) begin
      run_next = 1'b1;
      tmr_next = cet_pkg::TMR_ZERO;
    end else if (t_stop && run_reg) begin
      run_next = 1'b0;
    end
    if (emu_start) begin
      run_next = 1'b0;
    end
    trig_next = 1'b0;
    for (int m = 0; m < cet_pkg::NUM_MON; m++) begin
      if (bus_cycle && mon_enable[m] && bus_addr == mon_addr[m]) begin
        trig_next = 1'b1;
      end
    end
  end

  // Control state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      armed_reg    <= cet_pkg::ARM_RESET;
      brk_pend_reg <= 1'b0;
      brk_cnt_reg  <= cet_pkg::CNT_ZERO;
      break_reg    <= 1'b0;
      trace_reg    <= 1'b0;
      run_reg      <= 1'b0;
      tmr_reg      <= cet_pkg::TMR_ZERO;
      trig_reg     <= 1'b0;
    end else begin
      armed_reg    <= armed_next;
      brk_pend_reg <= brk_pend_next;
      brk_cnt_reg  <= brk_cnt_next;
      break_reg    <= break_next;
      trace_reg    <= trace_next;
      run_reg      <= run_next;
      tmr_reg      <= tmr_next;
      trig_reg     <= trig_next;
    end
  end

  assign ch_hit               = hits;
  assign break_out            = break_reg;
  assign trace_acquire        = trace_reg;
  assign timer_running        = run_reg;
  assign timer_count          = tmr_reg;
  assign trigger_probe_output = trig_reg;

  // Checks
  brk_now_a: assert property (@(posedge clock) disable iff (rst)
    brk_trig && !brk_pend_reg && !emu_start && !break_delay_en
    |=> break_out) else $error("undelayed break missing");
  brk_delay_a: assert property (@(posedge clock) disable iff (rst)
    brk_pend_reg && bus_cycle && !emu_start
    && brk_cnt_reg == cet_pkg::CNT_ONE |=> break_out && !brk_pend_reg)
    else $error("delayed break not on count end");
  brk_hold_a: assert property (@(posedge clock) disable iff (rst)
    brk_pend_reg && !bus_cycle && !emu_start |=> $stable(brk_cnt_reg))
    else $error("break delay moved without bus cycle");
  trig_mon_a: assert property (@(posedge clock) disable iff (rst)
    bus_cycle && mon_enable[0] && bus_addr == mon_addr[0]
    |=> trigger_probe_output) else $error("trigger probe missed");
  trig_idle_a: assert property (@(posedge clock) disable iff (rst)
    !bus_cycle |=> !trigger_probe_output)
    else $error("trigger without bus cycle");
  tmr_start_a: assert property (@(posedge clock) disable iff (rst)
    t_start && !run_reg && !emu_start
    |=> timer_running && timer_count == cet_pkg::TMR_ZERO)
    else $error("timer failed to start");
  tmr_count_a: assert property (@(posedge clock) disable iff (rst)
    run_reg ##1 run_reg |-> timer_count == $past(timer_count) + 1)
    else $error("timer did not advance");
  seq_arm_a: assert property (@(posedge clock) disable iff (rst)
    chain_en[1] && !chain_disarm[1] && hits[0] && !emu_start
    |=> armed_reg[1]) else $error("sequence stage not armed");
  start_clr_a: assert property (@(posedge clock) disable iff (rst)
    emu_start |=> !brk_pend_reg && !break_out && !timer_running)
    else $error("start did not clear state");
  trace_a: assert property (@(posedge clock) disable iff (rst)
    |(hits & trace_sel) |=> trace_acquire)
    else $error("trace acquire missed");
  probe_sync_a: assert property (@(posedge clock) disable iff (rst)
    sync2_reg[0] != sync3_reg[0] |=> $stable(probe_reg[0]))
    else $error("probe changed before agreeing");

  cov_break_c: cover property (@(posedge clock) break_out);
  cov_delay_c: cover property (@(posedge clock) brk_pend_reg ##1 break_out);
  cov_seq_c: cover property (@(posedge clock) hits[0] ##[1:50] hits[1]);
  cov_timer_c: cover property (@(posedge clock) run_reg ##1 !run_reg);
endmodule
`default_nettype wire

// >>> verif/cet_bus_model.sv
// Model of the emulated bus and the external probe pins
`default_nettype none
module cet_bus_model (
  input  wire logic                          clock,
  output var logic                           bus_cycle,
  output var logic [cet_pkg::ADDR_W-1:0]     bus_addr,
  output var logic [cet_pkg::DATA_W-1:0]     bus_data,
  output var logic                           bus_write,
  output var logic [cet_pkg::TYPE_W-1:0]     bus_type,
  output var logic [cet_pkg::AREA_W-1:0]     bus_area,
  output var logic [cet_pkg::NUM_PROBE-1:0]  probes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [cet_pkg::AREA_W-1:0] area;
  // Quiet bus and low probes at power up
  initial begin
    area = 2'h1;
    bus_cycle = 1'b0;
    bus_addr = '0;
    bus_data = '0;
    bus_write = 1'b0;
    bus_type = '0;
    bus_area = '0;
    probes = '0;
  end
  // One bus cycle, held through the next sampling edge
  task automatic cycle(input logic [cet_pkg::ADDR_W-1:0] a,
                       input logic [cet_pkg::DATA_W-1:0] d,
                       input logic w,
                       input logic [cet_pkg::TYPE_W-1:0] t);
    bus_cycle = 1'b1;
    bus_addr = a;
    bus_data = d;
    bus_write = w;
    bus_type = t;
    bus_area = area;
    @(negedge clock);
  endtask
  // Access area used by the following bus cycles
  task automatic set_area(input logic [cet_pkg::AREA_W-1:0] v);
    area = v;
  endtask
  // Released bus: fields turn over so stale values never look valid
  task automatic idle(input int n);
    bus_cycle = 1'b0;
    bus_addr = ~bus_addr;
    bus_data = ~bus_data;
    bus_write = ~bus_write;
    bus_type = ~bus_type;
    bus_area = ~bus_area;
    repeat (n) @(negedge clock);
  endtask
  task automatic set_probes(input logic [cet_pkg::NUM_PROBE-1:0] v);
    probes = v;
  endtask
endmodule
`default_nettype wire

// >>> verif/cet_top_tb_top.sv
// Self-checking bench for the event matching system
`default_nettype none
module cet_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC = cet_pkg::NUM_CH;
  localparam int NE = cet_pkg::NUM_EVT;
  localparam int AW = cet_pkg::ADDR_W;
  localparam int DW = cet_pkg::DATA_W;
  localparam int CW = cet_pkg::CNT_W;
  localparam int PW = cet_pkg::NUM_PROBE;
  logic                clock, rst, emu_start, bus_cycle, bus_write;
  logic                break_out, trace_acquire, timer_running;
  logic                trigger_probe_output, break_delay_en;
  logic [AW-1:0]       bus_addr;
  logic [DW-1:0]       bus_data;
  logic [2:0]          bus_type;
  logic [1:0]          bus_area;
  logic [PW-1:0]       probes;
  logic [NC-1:0]       ch_enable, break_sel, trace_sel, ch_hit;
  logic [NC-1:0][AW-1:0] ch_addr_lo, ch_addr_hi;
  logic [NC-1:0][DW-1:0] ch_data, ch_mask;
  logic [NC-1:0][1:0]  ch_dir;
  logic [NC-1:0][7:0]  ch_type;
  logic [NC-1:0][3:0]  ch_area;
  logic [NC-1:0][PW-1:0] ch_pcare, ch_pval;
  logic [NC-1:0][CW-1:0] ch_delay;
  logic [NE-1:0][CW-1:0] ev_count;
  logic [NE-1:0]       ev_outside;
  logic [NE-1:1]       chain_en, chain_disarm;
  logic [CW-1:0]       break_delay;
  logic [3:0]          timer_start_sel, timer_stop_sel;
  logic [3:0]          mon_enable;
  logic [3:0][AW-1:0]  mon_addr;
  logic [31:0]         timer_count;
  int                  fails, checks_done, cyc, wch, b;
  int                  t_hit, n_hit, t_brk, n_brk, t_trc, t_trg, n_trg, t_run;
  cet_bus_model bus (.clock, .bus_cycle, .bus_addr, .bus_data, .bus_write,
                     .bus_type, .bus_area, .probes);
  cet_top uut (.clock, .rst, .emu_start, .bus_cycle, .bus_addr, .bus_data,
    .bus_write, .bus_type, .bus_area, .level_probe_input(probes[0]),
    .probe_in(probes[PW-1:1]), .ch_enable, .ch_addr_lo, .ch_addr_hi,
    .ev_outside, .ch_data, .ch_mask, .ch_dir, .ch_type, .ch_area, .ch_pcare,
    .ch_pval, .ev_count, .ch_delay, .chain_en, .chain_disarm, .break_sel,
    .break_delay_en, .break_delay, .trace_sel, .timer_start_sel,
    .timer_stop_sel, .mon_enable, .mon_addr, .ch_hit, .break_out,
    .trace_acquire, .timer_running, .timer_count, .trigger_probe_output);
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Log the first high cycle of the watched hit, break, trace, trigger and timer running outputs, and count the cycles in which hit, break and trigger are high
  always @(posedge clock) begin
    #1;
    cyc++;
    if (ch_hit[wch] === 1'b1) n_hit++;
    if (ch_hit[wch] === 1'b1 && t_hit < 0) t_hit = cyc;
    if (break_out === 1'b1) n_brk++;
    if (break_out === 1'b1 && t_brk < 0) t_brk = cyc;
    if (trace_acquire === 1'b1 && t_trc < 0) t_trc = cyc;
    if (trigger_probe_output === 1'b1) n_trg++;
    if (trigger_probe_output === 1'b1 && t_trg < 0) t_trg = cyc;
    if (timer_running === 1'b1 && t_run < 0) t_run = cyc;
  end
  task automatic chk_time(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Every channel off, match fields wide open except the address range, which is 0 to 0
  task automatic clr();
    {ch_enable, break_sel, trace_sel, ev_outside} = '0;
    {ch_addr_lo, ch_addr_hi, ch_data, ch_mask, ch_delay, ev_count} = '0;
    {ch_pcare, ch_pval, chain_en, chain_disarm, mon_enable, mon_addr} = '0;
    ch_dir = {NC{2'h3}};
    ch_type = '1;
    ch_area = '1;
    {break_delay_en, break_delay} = '0;
    timer_start_sel = 4'hF;
    timer_stop_sel = 4'hF;
  endtask
  task automatic watch(input int ch);
    wch = ch;
    {t_hit, t_brk, t_trc, t_trg, t_run} = {5{-1}};
    {n_hit, n_brk, n_trg} = '0;
  endtask
  task automatic start();
    emu_start = 1'b1;
    @(negedge clock);
    emu_start = 1'b0;
  endtask
  task automatic t_basic();
    clr();
    {ch_enable[0], break_sel[0], trace_sel[0]} = 3'h7;
    ch_addr_lo[0] = 24'h000100;
    ch_addr_hi[0] = 24'h000100;
    ch_dir[0] = cet_pkg::DIR_WRITE;
    ch_type[0] = 8'h04;
    watch(0);
    start();
    b = cyc;
    bus.cycle(24'h000100, 16'h0000, 1'b0, 3'h2);
    bus.cycle(24'h000100, 16'h0000, 1'b1, 3'h1);
    bus.cycle(24'h000100, 16'h0000, 1'b1, 3'h2);
    bus.idle(4);
    chk_time(t_hit, b + 3);
    chk_time(n_hit, 1);
    chk_time(t_brk, b + 4);
    chk_time(t_trc, b + 4);
    $display("test basic done");
  endtask
  task automatic t_count();
    clr();
    ch_enable[0] = 1'b1;
    ch_addr_lo[0] = 24'h000200;
    ch_addr_hi[0] = 24'h000200;
    ch_data[0] = 16'h5A00;
    ch_mask[0] = 16'hFF00;
    ev_count[0] = 16'h0003;
    ch_delay[0] = 16'h0002;
    watch(0);
    start();
    bus.cycle(24'h000200, 16'h5A3C, 1'b0, 3'h0);
    bus.idle(1);
    start();
    b = cyc;
    repeat (3) bus.cycle(24'h000200, 16'h5AC3, 1'b1, 3'h0);
    bus.cycle(24'h000200, 16'h6A3C, 1'b1, 3'h0);
    bus.cycle(24'h000210, 16'h5A3C, 1'b1, 3'h0);
    bus.idle(4);
    chk_time(t_hit, b + 5);
    chk_time(n_hit, 1);
    $display("test count done");
  endtask
  task automatic t_chain();
    clr();
    ch_enable[1:0] = 2'h3;
    ch_addr_lo[0] = 24'h000300;
    ch_addr_hi[0] = 24'h000300;
    ch_addr_hi[1] = 24'h0FFFFF;
    ev_outside[1] = 1'b1;
    chain_en[1] = 1'b1;
    break_sel[1] = 1'b1;
    watch(1);
    start();
    b = cyc;
    bus.cycle(24'h400000, 16'h0000, 1'b0, 3'h0);
    bus.cycle(24'h000300, 16'h0000, 1'b0, 3'h0);
    bus.idle(1);
    bus.cycle(24'h400000, 16'h0000, 1'b0, 3'h0);
    bus.idle(4);
    chk_time(t_hit, b + 4);
    chk_time(n_hit, 1);
    chk_time(t_brk, b + 5);
    $display("test chain done");
  endtask
  task automatic t_break();
    clr();
    ch_enable[8] = 1'b1;
    ch_enable[0] = 1'b1;
    ch_addr_lo[8] = 24'h000500;
    ch_addr_hi[8] = 24'h00050F;
    ch_addr_lo[0] = 24'h000600;
    ch_addr_hi[0] = 24'h000600;
    break_sel[8] = 1'b1;
    break_delay_en = 1'b1;
    break_delay = 16'h0003;
    timer_start_sel = 4'h8;
    timer_stop_sel = 4'h0;
    watch(8);
    start();
    b = cyc;
    bus.cycle(24'h000505, 16'h1234, 1'b0, 3'h0);
    bus.idle(2);
    repeat (3) bus.cycle(24'h000700, 16'h1234, 1'b0, 3'h0);
    bus.cycle(24'h000600, 16'h1234, 1'b0, 3'h0);
    bus.idle(4);
    chk_time(t_hit, b + 1);
    chk_time(t_brk, b + 6);
    chk_time(t_run, b + 2);
    chk_val(timer_count, 32'h0000_0006);
    $display("test break done");
  endtask
  task automatic t_probe();
    clr();
    mon_enable[2] = 1'b1;
    mon_addr[2] = 24'h000800;
    {mon_enable[0], mon_addr[0]} = {1'b1, 24'h000900};
    ch_enable[2] = 1'b1;
    ch_addr_lo[2] = 24'h000900;
    ch_addr_hi[2] = 24'h000900;
    ch_pcare[2] = 4'h1;
    ch_pval[2] = 4'h1;
    watch(2);
    start();
    bus.set_probes(4'hE);
    bus.idle(5);
    b = cyc;
    bus.cycle(24'h000800, 16'h0000, 1'b1, 3'h0);
    bus.cycle(24'h000900, 16'h0000, 1'b1, 3'h0);
    bus.set_probes(4'h1);
    bus.idle(5);
    chk_time(n_hit, 0);
    chk_time(t_trg, b + 1);
    chk_time(n_trg, 2);
    b = cyc;
    bus.cycle(24'h000900, 16'h0000, 1'b1, 3'h0);
    bus.idle(3);
    chk_time(t_hit, b + 1);
    $display("test probe done");
  endtask
  // Chained event that starts armed and is disarmed; access area filter
  task automatic t_disarm();
    clr();
    ch_enable[1:0] = 2'h3;
    {ch_addr_lo[0], ch_addr_hi[0]} = {2{24'h000300}};
    {ch_addr_lo[1], ch_addr_hi[1]} = {2{24'h400000}};
    ch_area[1] = 4'h4;
    {chain_en[1], chain_disarm[1]} = 2'h3;
    watch(1);
    start();
    b = cyc;
    bus.cycle(24'h400000, 16'h0000, 1'b0, 3'h0);
    bus.set_area(2'h2);
    bus.cycle(24'h400000, 16'h0000, 1'b0, 3'h0);
    bus.cycle(24'h000300, 16'h0000, 1'b0, 3'h0);
    bus.idle(1);
    bus.cycle(24'h400000, 16'h0000, 1'b0, 3'h0);
    bus.set_area(2'h1);
    bus.idle(3);
    chk_time(t_hit, b + 2);
    chk_time(n_hit, 1);
    $display("test disarm done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    clr();
    {rst, emu_start, fails, checks_done, cyc, wch} = {1'b1, 1'b0, 128'h0};
    watch(0);
    repeat (6) @(negedge clock);
    rst = 1'b0;
    t_basic();
    t_count();
    t_chain();
    t_break();
    t_probe();
    t_disarm();
    end_of_test();
  end
  // Watchdog: the tests need about 75 cycles, allow far more
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
